/* rtl/mab_pkg.sv */
// shared constants and types of the alu / branch execution unit
`default_nettype none
package mab_pkg;

  typedef enum logic [4:0] {
    OP_ADC,
    OP_WADD,
    OP_SUBK,
    OP_SBC,
    OP_SBCK,
    OP_WSUB,
    OP_ANDK,
    OP_ORK,
    OP_BSET,
    OP_BCLR,
    OP_TEST,
    OP_JUMP_VIA_POINTER,
    OP_CALL_VIA_POINTER,
    OP_COMPARE_SKIP_EQUAL,
    OP_CPI,
    OP_SKBC,
    OP_SKBS
  } mab_op_type;

  // status flag positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam logic [7:0] SREG_RESET = 8'h00;

  // cycle counts per instruction class
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_WORD  = 2'h2;
  localparam logic [1:0] CYC_JUMP  = 2'h2;
  localparam logic [1:0] CYC_CALL  = 2'h3;
  localparam logic [1:0] CYC_SKIP2 = 2'h2;
  localparam logic [1:0] CYC_SKIP3 = 2'h3;

  // program counter steps, in words
  localparam logic [15:0] PC_RET   = 16'h0001;
  localparam logic [15:0] PC_SKIP1 = 16'h0002;
  localparam logic [15:0] PC_SKIP2 = 16'h0003;

  // register map of the bus slave
  localparam int unsigned AXI_ADDR_W  = 4;
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [3:0]  ADDR_COUNT  = 4'h8;
  localparam logic        CTRL_RESET  = 1'h1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

endpackage
`default_nettype wire

/* rtl/mab_addsub.sv */
// adder / subtractor with carry, half-carry and overflow outputs
`timescale 1ns/10ps
`default_nettype none
module mab_addsub #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  input  wire logic         sub,
  output logic      [W-1:0] sum,
  output logic              cOut,
  output logic              hOut,
  output logic              vOut
);
  logic [W:0] full;
  always_comb
  begin
    if (sub)
      full = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin};
    else
      full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    sum  = full[W-1:0];
    // bit W of a difference is the borrow out
    cOut = full[W];
    if (sub)
    begin
      hOut = (~a[3] & b[3]) | (b[3] & sum[3]) | (sum[3] & ~a[3]);
      vOut = (a[W-1] & ~b[W-1] & ~sum[W-1]) | (~a[W-1] & b[W-1] & sum[W-1]);
    end
    else
    begin
      hOut = (a[3] & b[3]) | (b[3] & ~sum[3]) | (~sum[3] & a[3]);
      vOut = (a[W-1] & b[W-1] & ~sum[W-1]) | (~a[W-1] & ~b[W-1] & sum[W-1]);
    end
  end
endmodule
`default_nettype wire

/* rtl/mab_axil.sv */
// axi4-lite register slave: control, status and retired count
`timescale 1ns/10ps
`default_nettype none
module mab_axil (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             ctrlEn,
  input  wire logic [7:0]  sreg,
  input  wire logic        busy,
  input  wire logic [31:0] retired
);
  logic [3:0] awAddrQ;
  logic       wBitQ;
  logic       wLane0Q;
  logic       doWrite;
  logic [3:0] wa;
  logic [3:0] ra;

  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wa = {awAddrQ[3:2], 2'h0};
  assign ra = {s_axi_araddr[3:2], 2'h0};

  // address and data are taken in either order, held until the response
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awAddrQ       <= 4'h0;
      wBitQ         <= 1'b0;
      wLane0Q       <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        awAddrQ       <= s_axi_awaddr;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        wBitQ        <= s_axi_wdata[0];
        wLane0Q      <= s_axi_wstrb[0];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mab_pkg::RESP_OKAY;
      ctrlEn       <= mab_pkg::CTRL_RESET;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      if (wa == mab_pkg::ADDR_CTRL && wLane0Q)
        ctrlEn <= wBitQ;
      // status and count ignore writes; unmapped words answer decode error
      if (wa == mab_pkg::ADDR_CTRL || wa == mab_pkg::ADDR_STATUS || wa == mab_pkg::ADDR_COUNT)
        s_axi_bresp <= mab_pkg::RESP_OKAY;
      else
        s_axi_bresp <= mab_pkg::RESP_DECERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= mab_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mab_pkg::RESP_OKAY;
      unique case (ra)
        mab_pkg::ADDR_CTRL:   s_axi_rdata <= {31'h0, ctrlEn};
        mab_pkg::ADDR_STATUS: s_axi_rdata <= {23'h0, busy, sreg};
        mab_pkg::ADDR_COUNT:  s_axi_rdata <= retired;
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= mab_pkg::RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* rtl/mab_exec.sv */
// execution unit for arithmetic, logic, compare, skip and indirect jump instructions
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Overview of operation
// - add with carry: Rd + Rr + C into Rd, Z C N V H, one cycle
// - word add: pair + K into pair, Z C N V S, two cycles
// - subtract constant: Rd - K into Rd, Z C N V H, one cycle
// - subtract with borrow: Rd - Rr - C into Rd, Z C N V H, one cycle
// - subtract constant with borrow: Rd - K - C, Z C N V H, one cycle
// - word subtract: pair - K into pair, Z C N V S, two cycles
// - and with constant: result to Rd, only Z N V, one cycle
// - or with constant: result to Rd, only Z N V, one cycle
// - masked set: Rd or mask into Rd, Z N V, one cycle
// - masked clear: Rd and (FF minus mask) into Rd, Z N V, one cycle
// - test: Rd and Rd, no write, Z N V set, one cycle
// - jump via pointer: pc from Z pair, no flags, two cycles
// - call via pointer: push return, pc from Z, no flags, three cycles
// - compare skip equal: skip next on match, no flags, one/two/three cycles
// - compare immediate: Rd - K unstored, Z N V C H, one cycle
// - skip on bit clear: skip next if bit zero, no flags, 1/2/3 cycles
// - skip on bit one: skip next if bit one, no flags, 1/2/3 cycles
// ****************************************************************
module mab_exec (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                instrValid,
  output logic                     instrReady,
  input  wire mab_pkg::mab_op_type op,
  input  wire logic [7:0]          dstVal,
  input  wire logic [7:0]          dstHiVal,
  input  wire logic [7:0]          srcVal,
  input  wire logic [2:0]          bitSel,
  input  wire logic [15:0]         zPtr,
  input  wire logic [15:0]         pc,
  input  wire logic                nextTwoWord,
  output logic                     regWrEn,
  output logic                     regWrWord,
  output logic [15:0]              regWrData,
  output logic [7:0]               sreg,
  output logic                     pcLoad,
  output logic [15:0]              pcValue,
  output logic                     pushEn,
  output logic [15:0]              pushData,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [3:0]          s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [3:0]          s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp
);
  // ****************************************************************
  // datapath
  // ****************************************************************
  logic        accept;
  logic        ctrlEn;
  logic [1:0]  waitQ;
  logic [31:0] countQ;
  logic        isSub8;
  logic        useCarry;
  logic [7:0]  r8;
  logic        c8;
  logic        h8;
  logic        v8;
  logic [15:0] r16;
  logic        c16;
  logic        v16;
  logic [7:0]  lg;
  logic        skip;
  logic [1:0]  cyc;
  logic        wrEn;
  logic        wrWord;
  logic [15:0] wrData;
  logic [7:0]  sregD;
  logic        pcLd;
  logic [15:0] pcV;
  logic        push;

  assign accept = instrValid && instrReady;
  assign isSub8 = op == mab_pkg::OP_SUBK || op == mab_pkg::OP_SBC
               || op == mab_pkg::OP_SBCK || op == mab_pkg::OP_CPI;
  assign useCarry = op == mab_pkg::OP_ADC || op == mab_pkg::OP_SBC
                 || op == mab_pkg::OP_SBCK;

  mab_addsub #(.W(8)) u_alu8 (
    .a    (dstVal),
    .b    (srcVal),
    .cin  (useCarry & sreg[mab_pkg::FLAG_C]),
    .sub  (isSub8),
    .sum  (r8),
    .cOut (c8),
    .hOut (h8),
    .vOut (v8)
  );

  // word constant is six bits wide, the top of srcVal is ignored
  mab_addsub #(.W(16)) u_alu16 (
    .a    ({dstHiVal, dstVal}),
    .b    ({10'h000, srcVal[5:0]}),
    .cin  (1'b0),
    .sub  (op == mab_pkg::OP_WSUB),
    .sum  (r16),
    .cOut (c16),
    .hOut (),
    .vOut (v16)
  );

  always_comb
  begin
    cyc    = mab_pkg::CYC_ONE;
    wrEn   = 1'b0;
    wrWord = 1'b0;
    wrData = {8'h00, r8};
    sregD  = sreg;
    pcLd   = 1'b0;
    pcV    = 16'(pc + (nextTwoWord ? mab_pkg::PC_SKIP2 : mab_pkg::PC_SKIP1));
    push   = 1'b0;
    skip   = 1'b0;
    unique case (op)
      mab_pkg::OP_ANDK: lg = dstVal & srcVal;
      mab_pkg::OP_ORK,
      mab_pkg::OP_BSET: lg = dstVal | srcVal;
      mab_pkg::OP_BCLR: lg = dstVal & (8'hFF - srcVal);
      default:          lg = dstVal & dstVal;
    endcase
    unique case (op)
      mab_pkg::OP_ADC, mab_pkg::OP_SUBK, mab_pkg::OP_SBC,
      mab_pkg::OP_SBCK, mab_pkg::OP_CPI:
      begin
        wrEn = op != mab_pkg::OP_CPI;
        sregD[mab_pkg::FLAG_Z] = r8 == 8'h00;
        sregD[mab_pkg::FLAG_C] = c8;
        sregD[mab_pkg::FLAG_N] = r8[7];
        sregD[mab_pkg::FLAG_V] = v8;
        sregD[mab_pkg::FLAG_H] = h8;
      end
      mab_pkg::OP_WADD, mab_pkg::OP_WSUB:
      begin
        cyc    = mab_pkg::CYC_WORD;
        wrEn   = 1'b1;
        wrWord = 1'b1;
        wrData = r16;
        sregD[mab_pkg::FLAG_Z] = r16 == 16'h0000;
        sregD[mab_pkg::FLAG_C] = c16;
        sregD[mab_pkg::FLAG_N] = r16[15];
        sregD[mab_pkg::FLAG_V] = v16;
        sregD[mab_pkg::FLAG_S] = r16[15] ^ v16;
      end
      mab_pkg::OP_ANDK, mab_pkg::OP_ORK, mab_pkg::OP_BSET,
      mab_pkg::OP_BCLR, mab_pkg::OP_TEST:
      begin
        wrEn   = op != mab_pkg::OP_TEST;
        wrData = {8'h00, lg};
        sregD[mab_pkg::FLAG_Z] = lg == 8'h00;
        sregD[mab_pkg::FLAG_N] = lg[7];
        sregD[mab_pkg::FLAG_V] = 1'b0;
      end
      mab_pkg::OP_JUMP_VIA_POINTER:
      begin
        cyc  = mab_pkg::CYC_JUMP;
        pcLd = 1'b1;
        pcV  = zPtr;
      end
      mab_pkg::OP_CALL_VIA_POINTER:
      begin
        cyc  = mab_pkg::CYC_CALL;
        pcLd = 1'b1;
        pcV  = zPtr;
        push = 1'b1;
      end
      mab_pkg::OP_COMPARE_SKIP_EQUAL, mab_pkg::OP_SKBC, mab_pkg::OP_SKBS:
      begin
        if (op == mab_pkg::OP_COMPARE_SKIP_EQUAL)
          skip = dstVal == srcVal;
        else if (op == mab_pkg::OP_SKBC)
          skip = !dstVal[bitSel];
        else
          skip = dstVal[bitSel];
        // an untaken skip falls through to the fetch's own increment
        if (skip)
        begin
          pcLd = 1'b1;
          cyc  = nextTwoWord ? mab_pkg::CYC_SKIP3 : mab_pkg::CYC_SKIP2;
        end
      end
    endcase
  end

  // ****************************************************************
  // issue pacing
  // ****************************************************************
  // ready drops for the extra cycles of a multi-cycle instruction;
  // clearing the enable only stops new issues, never one in flight
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitQ      <= 2'h0;
      instrReady <= 1'b0;
    end
    else if (accept)
    begin
      waitQ      <= 2'(cyc - 2'h1);
      instrReady <= (cyc == mab_pkg::CYC_ONE) && ctrlEn;
    end
    else if (waitQ != 2'h0)
    begin
      waitQ      <= 2'(waitQ - 2'h1);
      instrReady <= (waitQ == 2'h1) && ctrlEn;
    end
    else
      instrReady <= ctrlEn;
  end

  // ****************************************************************
  // results
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sreg <= mab_pkg::SREG_RESET;
    else if (accept)
      sreg <= sregD;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regWrEn   <= 1'b0;
      regWrWord <= 1'b0;
      regWrData <= 16'h0000;
    end
    else
    begin
      regWrEn   <= accept && wrEn;
      regWrWord <= accept && wrWord;
      if (accept)
        regWrData <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcLoad   <= 1'b0;
      pcValue  <= 16'h0000;
      pushEn   <= 1'b0;
      pushData <= 16'h0000;
    end
    else
    begin
      pcLoad <= accept && pcLd;
      pushEn <= accept && push;
      if (accept)
      begin
        pcValue  <= pcV;
        pushData <= 16'(pc + mab_pkg::PC_RET);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      countQ <= 32'h0;
    else if (accept)
      countQ <= 32'(countQ + 32'h1);
  end

  mab_axil u_regs (
    .clk           (clk),
    .rst_n         (rst_n),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .ctrlEn        (ctrlEn),
    .sreg          (sreg),
    .busy          (waitQ != 2'h0),
    .retired       (countQ)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_adc_sum: assert property (accept && op == mab_pkg::OP_ADC |=>
    regWrEn && regWrData[7:0] == 8'($past(dstVal) + $past(srcVal) + $past(sreg[0])))
    else $error("add with carry result wrong");
  a_word_busy: assert property (accept && op == mab_pkg::OP_WADD |=>
    !instrReady && regWrWord ##1 (instrReady == $past(ctrlEn)))
    else $error("word add not two cycles");
  a_sub_value: assert property (accept && op == mab_pkg::OP_SUBK |=>
    regWrData[7:0] == 8'($past(dstVal) - $past(srcVal)) && instrReady == $past(ctrlEn))
    else $error("subtract constant wrong");
  a_sbc_value: assert property (accept && (op == mab_pkg::OP_SBC ||
    op == mab_pkg::OP_SBCK) |=> regWrData[7:0]
    == 8'($past(dstVal) - $past(srcVal) - $past(sreg[0])))
    else $error("subtract with borrow wrong");
  a_sbck_carry: assert property (accept && op == mab_pkg::OP_SBCK |=>
    sreg[0] == ({1'b0, $past(dstVal)} < 9'({1'b0, $past(srcVal)} + $past(sreg[0]))))
    else $error("borrow flag wrong");
  a_wsub_value: assert property (accept && op == mab_pkg::OP_WSUB |=>
    regWrData == 16'({$past(dstHiVal), $past(dstVal)} - {10'h000, $past(srcVal[5:0])}))
    else $error("word subtract wrong");
  a_logic_flags: assert property (accept && (op == mab_pkg::OP_ANDK
    || op == mab_pkg::OP_ORK) |=> !sreg[3] && $stable(sreg[0]) && $stable(sreg[5]))
    else $error("logic op touched wrong flags");
  a_bit_clear: assert property (accept && op == mab_pkg::OP_BCLR |=>
    regWrData[7:0] == ($past(dstVal) & ~$past(srcVal)))
    else $error("masked clear wrong");
  a_test_nowrite: assert property (accept && (op == mab_pkg::OP_TEST
    || op == mab_pkg::OP_CPI) |=> !regWrEn)
    else $error("test or compare wrote a register");
  a_call_push: assert property (accept && op == mab_pkg::OP_CALL_VIA_POINTER |=>
    pushEn && pcLoad && pcValue == $past(zPtr) && $stable(sreg) ##1 !instrReady)
    else $error("call via pointer wrong");
  a_skip_step: assert property (accept && pcLd && op != mab_pkg::OP_JUMP_VIA_POINTER
    && op != mab_pkg::OP_CALL_VIA_POINTER |=> pcValue == 16'($past(pc) + 16'h0002
    + {15'h0000, $past(nextTwoWord)}) && $stable(sreg))
    else $error("skip target wrong");
  a_sign_flag: assert property (accept && op == mab_pkg::OP_WSUB |=>
    sreg[4] == (sreg[2] ^ sreg[3]))
    else $error("sign flag not n xor v");

  c_call: cover property (accept && op == mab_pkg::OP_CALL_VIA_POINTER);
  c_skip3: cover property (accept && skip && nextTwoWord);
  c_word: cover property (accept && op == mab_pkg::OP_WADD ##2 accept);
  c_stall: cover property (!ctrlEn ##1 instrValid);
endmodule
`default_nettype wire

/* dv/mab_core_model.sv */
// far-side model: program counter and return stack fed by the unit
`timescale 1ns/10ps
`default_nettype none
module mab_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pcLoad,
  input  wire logic [15:0] pcValue,
  input  wire logic        pushEn,
  input  wire logic [15:0] pushData,
  output logic      [15:0] pcQ,
  output logic      [15:0] topQ
);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) pcQ <= 16'h0000;
    else if (pcLoad) pcQ <= pcValue;
  // only the top of the stack is kept, one push per call
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) topQ <= 16'h0000;
    else if (pushEn) topQ <= pushData;
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking bench of the execution unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
  logic clk, rst_n, instrValid, instrReady, nextTwoWord, regWrEn, regWrWord, pcLoad, pushEn;
  mab_pkg::mab_op_type op, rOp;
  logic [7:0] dstVal, dstHiVal, srcVal, sreg, mF, rD;
  logic [2:0] bitSel;
  logic [15:0] zPtr, pc, regWrData, pcValue, pushData, pcQ, topQ, eD, eV;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic eW, eWd, eP;
  int eX, mismatches, check_count, cnt;
  mab_exec dut (.clk, .rst_n, .instrValid, .instrReady, .op, .dstVal, .dstHiVal, .srcVal,
    .bitSel, .zPtr, .pc, .nextTwoWord, .regWrEn, .regWrWord, .regWrData, .sreg, .pcLoad,
    .pcValue, .pushEn, .pushData, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  mab_core_model rf (.clk, .rst_n, .pcLoad, .pcValue, .pushEn, .pushData, .pcQ, .topQ);
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // expected outputs of one instruction; mF carries the flags between calls
  function automatic void calc(mab_pkg::mab_op_type o, logic [7:0] d, dh, s, logic [2:0] b,
    logic [15:0] z, p, logic t);
    logic [8:0] r;
    logic [16:0] w;
    logic [4:0] h;
    logic ci, sb, tk;
    {eW, eWd, eP, eD, eV, eX} = '0;
    case (o)
      mab_pkg::OP_ADC, mab_pkg::OP_SUBK, mab_pkg::OP_SBC, mab_pkg::OP_SBCK, mab_pkg::OP_CPI:
      begin
        sb = o != mab_pkg::OP_ADC;
        ci = (o inside {mab_pkg::OP_ADC, mab_pkg::OP_SBC, mab_pkg::OP_SBCK}) & mF[0];
        r = sb ? {1'b0, d} - s - ci : {1'b0, d} + s + ci;
        h = sb ? {1'b0, d[3:0]} - s[3:0] - ci : {1'b0, d[3:0]} + s[3:0] + ci;
        mF[0] = r[8];
        mF[1] = r[7:0] == 8'h00;
        mF[2] = r[7];
        mF[3] = (sb ? d[7] != s[7] : d[7] == s[7]) && r[7] != d[7];
        mF[5] = h[4];
        eW = o != mab_pkg::OP_CPI;
        eD = {8'h00, r[7:0]};
      end
      mab_pkg::OP_WADD, mab_pkg::OP_WSUB:
      begin
        sb = o == mab_pkg::OP_WSUB;
        w = sb ? {1'b0, dh, d} - s[5:0] : {1'b0, dh, d} + s[5:0];
        mF[0] = w[16];
        mF[1] = w[15:0] == 16'h0000;
        mF[2] = w[15];
        mF[3] = sb ? dh[7] & ~w[15] : ~dh[7] & w[15];
        mF[4] = mF[2] ^ mF[3];
        {eW, eWd, eD, eX} = {2'b11, w[15:0], 32'd1};
      end
      mab_pkg::OP_JUMP_VIA_POINTER, mab_pkg::OP_CALL_VIA_POINTER:
        {eP, eV, eX} = {1'b1, z, (o == mab_pkg::OP_CALL_VIA_POINTER) ? 32'd2 : 32'd1};
      mab_pkg::OP_COMPARE_SKIP_EQUAL, mab_pkg::OP_SKBC, mab_pkg::OP_SKBS:
      begin
        tk = (o == mab_pkg::OP_COMPARE_SKIP_EQUAL) ? d == s : d[b] == (o == mab_pkg::OP_SKBS);
        if (tk) {eP, eV, eX} = {1'b1, p + (t ? 16'h0003 : 16'h0002), t ? 32'd2 : 32'd1};
      end
      default:
      begin
        r[7:0] = (o == mab_pkg::OP_ANDK) ? d & s : (o == mab_pkg::OP_BCLR) ? d & (8'hFF - s) :
          (o == mab_pkg::OP_TEST) ? d : d | s;
        mF[3:1] = {1'b0, r[7], r[7:0] == 8'h00};
        eW = o != mab_pkg::OP_TEST;
        eD = {8'h00, r[7:0]};
      end
    endcase
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic run(mab_pkg::mab_op_type o, logic [7:0] d, dh, s, logic [2:0] b, logic t);
    logic [15:0] z, p;
    int n;
    z = 16'($urandom);
    p = 16'($urandom);
    if (o inside {mab_pkg::OP_SKBC, mab_pkg::OP_SKBS}) s = d;
    @(posedge clk);
    op <= o;
    {instrValid, dstVal, dstHiVal, srcVal, bitSel, zPtr, pc, nextTwoWord} <=
      {1'b1, d, dh, s, b, z, p, t};
    n = 0;
    @(negedge clk);
    while (instrReady !== 1'b1 && n < 50) begin n++; @(negedge clk); end
    if (n == 50) begin mismatches++; results; end
    calc(o, d, dh, s, b, z, p, t);
    cnt++;
    @(posedge clk);
    instrValid <= 1'b0;
    @(negedge clk);
    `CHK("wr", eW, regWrEn)
    `CHK("word", eWd, regWrWord)
    if (eW) `CHK("data", eD, regWrData)
    `CHK("flags", mF, sreg)
    `CHK("pcld", eP, pcLoad)
    if (eP) `CHK("pcv", eV, pcValue)
    `CHK("push", o == mab_pkg::OP_CALL_VIA_POINTER, pushEn)
    if (o == mab_pkg::OP_CALL_VIA_POINTER) `CHK("ret", p + 16'h0001, pushData)
    n = 0;
    while (instrReady !== 1'b1 && n < 9) begin n++; @(negedge clk); end
    `CHK("cycles", eX, n)
    if (eP) `CHK("pcq", eV, pcQ)
    if (o == mab_pkg::OP_CALL_VIA_POINTER) `CHK("top", p + 16'h0001, topQ)
  endtask
  task automatic ax(logic w, logic [3:0] a, logic [31:0] wd, ed, logic [1:0] er);
    int n;
    @(posedge clk);
    if (w) {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'b111, a, wd};
    else {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'b11, a};
    n = 0;
    // loop body first: the request raised above is not yet visible in this time step
    do
    begin
      n++;
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin `CHK("bresp", er, s_axi_bresp) s_axi_bready <= 0; end
      if (s_axi_rvalid && s_axi_rready)
      begin
        `CHK("rresp", er, s_axi_rresp)
        `CHK("rdata", ed, s_axi_rdata)
        s_axi_rready <= 1'b0;
      end
    end
    while ((s_axi_awvalid || s_axi_wvalid || s_axi_arvalid || s_axi_bready || s_axi_rready)
      && n < 50);
    if (n == 50) begin mismatches++; results; end
  endtask
  initial
  begin
    {rst_n, instrValid, dstVal, dstHiVal, srcVal, bitSel, zPtr, pc, nextTwoWord} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 32'h0, 4'hF};
    op = mab_pkg::OP_ADC;
    {mF, mismatches, check_count, cnt} = '0;
    void'($urandom(3));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    run(mab_pkg::OP_SUBK, 8'h00, 8'h00, 8'h01, 3'h0, 1'b0);
    run(mab_pkg::OP_ADC, 8'hFF, 8'h00, 8'h01, 3'h0, 1'b0);
    run(mab_pkg::OP_WADD, 8'hFF, 8'h7F, 8'h3F, 3'h0, 1'b0);
    run(mab_pkg::OP_WSUB, 8'h00, 8'h00, 8'h01, 3'h0, 1'b0);
    run(mab_pkg::OP_COMPARE_SKIP_EQUAL, 8'h5A, 8'h00, 8'h5A, 3'h0, 1'b1);
    run(mab_pkg::OP_SKBS, 8'h80, 8'h00, 8'h00, 3'h7, 1'b1);
    run(mab_pkg::OP_BCLR, 8'hFF, 8'h00, 8'hF0, 3'h0, 1'b0);
    repeat (400)
    begin
      rOp = mab_pkg::mab_op_type'($urandom_range(16));
      rD = 8'($urandom);
      run(rOp, rD, 8'($urandom), ($urandom_range(3) == 0) ? rD : 8'($urandom),
        3'($urandom), 1'($urandom));
    end
    ax(1'b0, mab_pkg::ADDR_STATUS, 32'h0, {24'h0, mF}, mab_pkg::RESP_OKAY);
    ax(1'b0, mab_pkg::ADDR_COUNT, 32'h0, cnt, mab_pkg::RESP_OKAY);
    ax(1'b0, 4'hC, 32'h0, 32'h0, mab_pkg::RESP_DECERR);
    ax(1'b1, 4'hC, 32'h1, 32'h0, mab_pkg::RESP_DECERR);
    ax(1'b1, mab_pkg::ADDR_CTRL, 32'h0, 32'h0, mab_pkg::RESP_OKAY);
    @(negedge clk);
    `CHK("hold", 1'b0, instrReady)
    ax(1'b1, mab_pkg::ADDR_CTRL, 32'h1, 32'h0, mab_pkg::RESP_OKAY);
    ax(1'b0, mab_pkg::ADDR_CTRL, 32'h0, 32'h1, mab_pkg::RESP_OKAY);
    run(mab_pkg::OP_TEST, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0);
    results;
  end
endmodule
`default_nettype wire
